// ===== rtl/system_address_map_write_buffer.sv
// address decoder and processor write buffer for the system bus
`timescale 1ns/100ps
module system_address_map_write_buffer
	import addr_map_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RSTN,
	// configuration from the processor control register and size register
	input  wire logic                WRITE_BUFFER_EN,
	input  wire logic [1:0]          SRAM_SIZE_SEL,
	// processor / master request
	input  wire logic                REQ_VALID,
	input  wire logic                REQ_WRITE,
	input  wire logic                REQ_FROM_CPU,
	input  wire logic [ADDR_W-1:0]   REQ_ADDR,
	input  wire logic [DATA_W-1:0]   REQ_WDATA,
	output logic                     REQ_READY,
	output logic [DATA_W-1:0]        REQ_RDATA,
	output logic                     REQ_ERROR,
	// tightly coupled data port
	output logic                     TCM_SEL,
	output logic [ADDR_W-1:0]        TCM_ADDR,
	// downstream system bus
	output logic                     BUS_VALID,
	output logic                     BUS_WRITE,
	output logic [ADDR_W-1:0]        BUS_ADDR,
	output logic [DATA_W-1:0]        BUS_WDATA,
	output logic [2:0]               BUS_TARGET,
	output logic [BRIDGE_OFS_W-1:0]  BUS_BRIDGE_OFS,
	output logic                     FLASH_CS0,
	input  wire logic                BUS_DONE,
	input  wire logic [DATA_W-1:0]   BUS_RDATA,
	// status
	output logic                     BUFFER_EMPTY,
	output logic                     BUFFER_FULL
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [ADDR_W-1:0]  fifo_addr [DEPTH];
	logic [DATA_W-1:0]  fifo_data [DEPTH];
	logic [PTR_W-1:0]   wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [PTR_W:0]     count, next_count;
	logic               wb_en, next_wb_en;
	logic [1:0]         sram_size, next_sram_size;
	bus_state_t         state, next_state;
	logic [ADDR_W-1:0]  bus_addr, next_bus_addr;
	logic [DATA_W-1:0]  bus_wdata, next_bus_wdata;
	logic               bus_write, next_bus_write;
	logic [DATA_W-1:0]  rdata, next_rdata;
	logic               rerror, next_rerror;
	logic               tcm_sel, next_tcm_sel;
	logic [ADDR_W-1:0]  tcm_addr, next_tcm_addr;

	logic [5:0]         region;
	logic               buffered_alias, decode_hit, in_tcm, sram_in_range;
	logic [16:0]        sram_bytes;
	logic               push, pop, fifo_full, fifo_empty, take_direct, take_tcm;

	// decode of the full 32-bit space on 64 MB regions
	function automatic target_t decode(input logic [ADDR_W-1:0] a);
		logic [5:0] r;
		r = a[REGION_HI:REGION_LO];
		if (r == FLASH_REGION)
			return TGT_FLASH;
		else if (r == TCM_REGION)
			return TGT_TCM;
		else if (r == SRAM_BUF || r == SRAM_UNBUF)
			return TGT_SRAM;
		else if (r == BRIDGE0_BUF || r == BRIDGE0_UNBUF)
			return TGT_BRIDGE0;
		else if (r == BRIDGE1_BUF || r == BRIDGE1_UNBUF)
			return TGT_BRIDGE1;
		else if ((r >= HIGH_BUF_LO && r <= HIGH_UNBUF_HI) || r == TOP_UNBUF)
			return TGT_SYSBUS;
		else
			return TGT_NONE;
	endfunction : decode

	always_comb begin
		region = REQ_ADDR[REGION_HI:REGION_LO];
		// buffered alias of sram, both bridges and the high windows sits below its unbuffered twin
		buffered_alias = (region == SRAM_BUF) || (region == BRIDGE0_BUF) ||
			(region == BRIDGE1_BUF) ||
			(region >= HIGH_BUF_LO && region <= HIGH_BUF_HI);
		unique case (sram_size)
			SRAM_64K: sram_bytes = SRAM_64K_BYTES;
			SRAM_96K: sram_bytes = SRAM_96K_BYTES;
			default:  sram_bytes = SRAM_32K_BYTES;
		endcase
		sram_in_range = ({9'h000, REQ_ADDR[25:0]} < {18'h00000, sram_bytes});
		in_tcm = (decode(REQ_ADDR) == TGT_TCM);
		// other masters have no tcm path, so their tcm alias access is unmapped
		decode_hit = (decode(REQ_ADDR) != TGT_NONE) && !(in_tcm && !REQ_FROM_CPU) &&
			(!(in_tcm || decode(REQ_ADDR) == TGT_SRAM) || sram_in_range);
	end

	assign fifo_full  = (count == (PTR_W+1)'(DEPTH));
	assign fifo_empty = (count == '0);

	// only the processor, with buffering on, writing a buffered alias, queues
	always_comb begin
		push = REQ_VALID && REQ_WRITE && REQ_FROM_CPU && wb_en && buffered_alias &&
			decode_hit && !fifo_full && state != ST_DIRECT;
		// direct access waits for the queue to empty so ordering holds
		take_direct = REQ_VALID && decode_hit && !in_tcm && !push && state == ST_IDLE &&
			fifo_empty;
		take_tcm = REQ_VALID && in_tcm && decode_hit && REQ_FROM_CPU && state != ST_DIRECT;
		pop = (state == ST_DRAIN) && BUS_DONE;
	end

	always_comb begin
		REQ_READY = push || take_tcm || (REQ_VALID && !decode_hit) ||
			(state == ST_DIRECT && BUS_DONE);
	end

	always_comb begin
		next_wb_en     = WRITE_BUFFER_EN;
		next_sram_size = SRAM_SIZE_SEL;
		next_wr_ptr    = push ? wr_ptr + (PTR_W)'(1) : wr_ptr;
		next_rd_ptr    = pop ? rd_ptr + (PTR_W)'(1) : rd_ptr;
		next_count     = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		next_state     = state;
		next_bus_addr  = bus_addr;
		next_bus_wdata = bus_wdata;
		next_bus_write = bus_write;
		next_rdata     = rdata;
		next_rerror    = REQ_VALID && !decode_hit;
		next_tcm_sel   = take_tcm;
		next_tcm_addr  = take_tcm ? REQ_ADDR : tcm_addr;
		unique case (state)
			ST_IDLE: begin
				if (!fifo_empty) begin
					next_state     = ST_DRAIN;
					next_bus_addr  = fifo_addr[rd_ptr];
					next_bus_wdata = fifo_data[rd_ptr];
					next_bus_write = 1'b1;
				end else if (take_direct) begin
					next_state     = ST_DIRECT;
					next_bus_addr  = REQ_ADDR;
					next_bus_wdata = REQ_WDATA;
					next_bus_write = REQ_WRITE;
				end
			end
			ST_DRAIN: begin
				if (BUS_DONE)
					next_state = ST_IDLE;
			end
			ST_DIRECT: begin
				if (BUS_DONE) begin
					next_state = ST_IDLE;
					next_rdata = BUS_RDATA;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			wb_en     <= 1'b0;
			sram_size <= SRAM_32K;
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			state     <= ST_IDLE;
			bus_addr  <= '0;
			bus_wdata <= '0;
			bus_write <= 1'b0;
			rdata     <= '0;
			rerror    <= 1'b0;
			tcm_sel   <= 1'b0;
			tcm_addr  <= '0;
		end else begin
			wb_en     <= next_wb_en;
			sram_size <= next_sram_size;
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			state     <= next_state;
			bus_addr  <= next_bus_addr;
			bus_wdata <= next_bus_wdata;
			bus_write <= next_bus_write;
			rdata     <= next_rdata;
			rerror    <= next_rerror;
			tcm_sel   <= next_tcm_sel;
			tcm_addr  <= next_tcm_addr;
		end
	end

	// queue storage needs no reset; entries are valid only between pointers
	always_ff @(posedge CLK) begin
		if (push) begin
			fifo_addr[wr_ptr] <= REQ_ADDR;
			fifo_data[wr_ptr] <= REQ_WDATA;
		end
	end

	always_comb begin
		BUS_VALID      = (state != ST_IDLE);
		BUS_WRITE      = bus_write;
		BUS_ADDR       = bus_addr;
		BUS_WDATA      = bus_wdata;
		BUS_TARGET     = (state != ST_IDLE) ? 3'(decode(bus_addr)) : 3'(TGT_NONE);
		BUS_BRIDGE_OFS = bus_addr[BRIDGE_OFS_W-1:0];
		FLASH_CS0      = (state != ST_IDLE) && (decode(bus_addr) == TGT_FLASH);
		REQ_RDATA      = rdata;
		REQ_ERROR      = rerror;
		TCM_SEL        = tcm_sel;
		TCM_ADDR       = tcm_addr;
		BUFFER_EMPTY   = fifo_empty;
		BUFFER_FULL    = fifo_full;
	end
endmodule : system_address_map_write_buffer

// ===== rtl/addr_map_pkg.sv
// constants for the system address map and write buffer
package addr_map_pkg;
	localparam int          ADDR_W         = 32;
	localparam int          DATA_W         = 32;
	localparam int          FIFO_DEPTH     = 4;
	// region decode on the top six address bits (64 MB windows)
	localparam int          REGION_HI      = 31;
	localparam int          REGION_LO      = 26;
	localparam logic [5:0]  FLASH_REGION   = 6'h00; // 0x0000_0000
	localparam logic [5:0]  TCM_REGION     = 6'h01; // 0x0400_0000
	localparam logic [5:0]  SRAM_BUF       = 6'h10; // 0x4000_0000
	localparam logic [5:0]  BRIDGE0_BUF    = 6'h12; // 0x4800_0000
	localparam logic [5:0]  BRIDGE1_BUF    = 6'h13; // 0x4c00_0000
	localparam logic [5:0]  SRAM_UNBUF     = 6'h14; // 0x5000_0000
	localparam logic [5:0]  BRIDGE0_UNBUF  = 6'h16; // 0x5800_0000
	localparam logic [5:0]  BRIDGE1_UNBUF  = 6'h17; // 0x5c00_0000
	// high system-bus windows: buffered alias below, unbuffered alias four regions up
	localparam logic [5:0]  HIGH_BUF_LO    = 6'h18; // 0x6000_0000
	localparam logic [5:0]  HIGH_BUF_HI    = 6'h1b;
	localparam logic [5:0]  HIGH_UNBUF_LO  = 6'h1c; // 0x7000_0000
	localparam logic [5:0]  HIGH_UNBUF_HI  = 6'h1f;
	localparam logic [5:0]  TOP_UNBUF      = 6'h3f; // 0xfc00_0000
	// sram size codes
	localparam logic [1:0]  SRAM_32K       = 2'h0;
	localparam logic [1:0]  SRAM_64K       = 2'h1;
	localparam logic [1:0]  SRAM_96K       = 2'h2;
	localparam logic [16:0] SRAM_32K_BYTES = 17'h08000;
	localparam logic [16:0] SRAM_64K_BYTES = 17'h10000;
	localparam logic [16:0] SRAM_96K_BYTES = 17'h18000;
	localparam int          BRIDGE_OFS_W   = 26;
	typedef enum logic [2:0] {
		TGT_NONE   = 3'h0,
		TGT_FLASH  = 3'h1,
		TGT_TCM    = 3'h2,
		TGT_SRAM   = 3'h3,
		TGT_BRIDGE0 = 3'h4,
		TGT_BRIDGE1 = 3'h5,
		TGT_SYSBUS = 3'h6
	} target_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DRAIN = 3'b010,
		ST_DIRECT = 3'b100
	} bus_state_t;
endpackage : addr_map_pkg

// ===== tb/addr_map_monitor.sv
// port assertions for the address map and write buffer
`timescale 1ns/100ps
module addr_map_monitor
	import addr_map_pkg::*;
(
	// control and request
	input wire logic CLK, RSTN, WRITE_BUFFER_EN, REQ_VALID, REQ_WRITE, REQ_FROM_CPU, REQ_READY,
	input wire logic [ADDR_W-1:0]       REQ_ADDR,
	// outputs and bus
	input wire logic TCM_SEL, BUS_VALID, BUS_DONE, FLASH_CS0, BUFFER_FULL, BUFFER_EMPTY,
	input wire logic [ADDR_W-1:0]       TCM_ADDR, BUS_ADDR,
	input wire logic [DATA_W-1:0]       BUS_WDATA,
	input wire logic [2:0]              BUS_TARGET,
	input wire logic [BRIDGE_OFS_W-1:0] BUS_BRIDGE_OFS
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence taken;
		REQ_VALID && REQ_READY;
	endsequence
	// write inside the smallest sram size at region r
	sequence sram_wr(logic [5:0] r);
		REQ_VALID && REQ_WRITE && REQ_ADDR[31:26] == r && REQ_ADDR[25:15] == 11'h000;
	endsequence
	a_flash_select: assert property (
		BUS_VALID && BUS_ADDR[31:26] == FLASH_REGION |-> FLASH_CS0) else $error("no flash select");
	a_full_stalls: assert property (
		REQ_VALID && REQ_WRITE && BUFFER_FULL |-> !REQ_READY) else $error("taken while full");
	a_buffered_free: assert property (
		sram_wr(SRAM_BUF) ##0 REQ_FROM_CPU && !BUFFER_FULL && WRITE_BUFFER_EN
		&& $past(WRITE_BUFFER_EN) |-> REQ_READY) else $error("buffered write stalled");
	a_unbuf_direct: assert property (
		sram_wr(SRAM_UNBUF) ##0 taken |-> BUS_VALID && BUS_DONE) else $error("not direct");
	a_other_master: assert property (
		sram_wr(SRAM_BUF) ##0 taken ##0 !REQ_FROM_CPU |-> BUS_DONE) else $error("dma buffered");
	a_disabled_direct: assert property (
		sram_wr(SRAM_BUF) ##0 taken ##0 !$past(WRITE_BUFFER_EN) |-> BUS_DONE)
		else $error("buffered while disabled");
	a_read_direct: assert property (
		taken ##0 !REQ_WRITE && REQ_ADDR[31:26] == FLASH_REGION |-> BUS_DONE && BUFFER_EMPTY)
		else $error("read not direct");
	a_tcm_route: assert property (
		taken ##0 REQ_FROM_CPU && REQ_ADDR[31:26] == TCM_REGION && REQ_ADDR[25:15] == 11'h000
		|=> TCM_SEL && TCM_ADDR == $past(REQ_ADDR)) else $error("tcm not selected");
	a_tcm_other: assert property (
		taken ##0 !REQ_FROM_CPU && REQ_ADDR[31:26] == TCM_REGION |=> !TCM_SEL)
		else $error("tcm used by other master");
	a_flash_only: assert property (
		FLASH_CS0 |-> BUS_VALID && BUS_ADDR[31:26] == FLASH_REGION) else $error("stray flash select");
	a_bridge_decode: assert property (
		BUS_VALID && BUS_ADDR[31:28] == 4'h4 && BUS_ADDR[27] |-> BUS_BRIDGE_OFS == BUS_ADDR[25:0]
		&& BUS_TARGET == (BUS_ADDR[26] ? TGT_BRIDGE1 : TGT_BRIDGE0)) else $error("bad bridge");
	a_bus_hold: assert property (
		BUS_VALID && !BUS_DONE |=> BUS_VALID && $stable(BUS_ADDR) && $stable(BUS_WDATA))
		else $error("bus transfer changed");
endmodule : addr_map_monitor

bind system_address_map_write_buffer addr_map_monitor i_addr_map_monitor (.*);

// ===== tb/bus_responder.sv
// system bus target model, answering after a short or a long wait
`timescale 1ns/100ps
module bus_responder (
	input wire logic        CLK, BUS_VALID, slow,
	input wire logic [31:0] BUS_ADDR,
	output logic            BUS_DONE = 1'b0,
	output logic [31:0]     BUS_RDATA = 32'h0
);
	int cnt = 0;
	// data means nothing outside the done pulse, so it keeps moving
	always @(posedge CLK) begin
		cnt <= (BUS_VALID && !BUS_DONE) ? cnt + 1 : 0;
		BUS_DONE <= BUS_VALID && !BUS_DONE && cnt >= (slow ? 6 : 1);
		BUS_RDATA <= (BUS_VALID && !BUS_DONE && cnt >= (slow ? 6 : 1)) ? ~BUS_ADDR
			: {BUS_RDATA[30:0], ~BUS_RDATA[31]};
	end
endmodule : bus_responder

// ===== tb/testbench.sv
// self-checking bench for the address map and write buffer
`timescale 1ns/100ps
module testbench;
	import addr_map_pkg::*;
	logic CLK = 0, RSTN = 0, WRITE_BUFFER_EN = 0, REQ_VALID = 0, REQ_WRITE = 0, REQ_FROM_CPU = 1;
	logic [1:0] SRAM_SIZE_SEL = SRAM_32K;
	logic [31:0] REQ_ADDR = 0, REQ_WDATA = 0, REQ_RDATA, TCM_ADDR, BUS_ADDR, BUS_WDATA, BUS_RDATA;
	logic REQ_READY, REQ_ERROR, TCM_SEL, BUS_VALID, BUS_WRITE, FLASH_CS0, BUS_DONE;
	logic BUFFER_EMPTY, BUFFER_FULL, slow = 0, stalled = 0, full_seen = 0;
	logic [2:0] BUS_TARGET;
	logic [25:0] BUS_BRIDGE_OFS;
	logic [67:0] notes[$];
	logic [31:0] wa[4] = '{32'h4000_0020, 32'h4800_1004, 32'h4c00_e008, 32'h6000_0100};
	logic [2:0] wt[4] = '{TGT_SRAM, TGT_BRIDGE0, TGT_BRIDGE1, TGT_SYSBUS};
	int fails = 0, checks_done = 0, cycles = 0, waited;
	system_address_map_write_buffer i_system_address_map_write_buffer (.*);
	bus_responder i_bus_responder (.*);
	always #5 CLK = ~CLK;
	task automatic check(logic [67:0] got, logic [67:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic conclude;
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			$display("wrong value at %0t: run timed out", $time);
			conclude();
		end
	end
	// every finished bus transfer must match the oldest note
	always @(posedge CLK) if (RSTN && BUS_VALID && BUS_DONE) begin
		if (notes.size() == 0) check(1, 0);
		else check({BUS_WRITE, BUS_TARGET, BUS_ADDR, BUS_WRITE ? BUS_WDATA : 32'h0},
			notes.pop_front());
	end
	// holds the request until taken; leaves it up for back-to-back use
	task automatic req(bit wr, bit cpu, logic [31:0] a, logic [2:0] tgt, bit on_bus);
		logic [31:0] d;
		d = $urandom;
		waited = 0;
		REQ_VALID <= 1;
		REQ_WRITE <= wr;
		REQ_FROM_CPU <= cpu;
		REQ_ADDR <= a;
		REQ_WDATA <= d;
		if (on_bus) notes.push_back({wr, tgt, a, wr ? d : 32'h0});
		do begin
			@(negedge CLK);
			full_seen |= BUFFER_FULL && !REQ_READY;
		end while (!REQ_READY && ++waited < 300);
		@(posedge CLK);
		if (waited >= 300) begin
			fails++;
			$display("wrong value at %0t: request never taken", $time);
		end
	endtask : req
	task automatic rest;
		REQ_VALID <= 0;
		@(posedge CLK);
	endtask : rest
	task automatic rd(logic [31:0] a, logic [2:0] tgt, bit err);
		req(0, 1, a, tgt, !err);
		REQ_VALID <= 0;
		@(negedge CLK);
		check({REQ_ERROR, err ? 32'h0 : REQ_RDATA}, {err, err ? 32'h0 : ~a});
		@(posedge CLK);
	endtask : rd
	initial begin
		void'($urandom(78));
		repeat (20) @(posedge CLK);
		RSTN <= 1;
		@(posedge CLK);
		rd(32'h0000_0000, TGT_FLASH, 0);
		slow <= 1;
		req(1, 1, 32'h4000_0010, TGT_SRAM, 1);
		rest();
		check(waited > 2, 1);
		WRITE_BUFFER_EN <= 1;
		repeat (2) @(posedge CLK);
		for (int i = 0; i < 8; i++) begin
			req(1, 1, wa[i%4] + 32'(4*i), wt[i%4], 1);
			if (i < 4) check(waited, 0);
			stalled |= waited > 2;
		end
		rest();
		check(stalled, 1);
		check(full_seen, 1);
		rd(32'h5000_0040, TGT_SRAM, 0);
		req(1, 0, 32'h4000_0030, TGT_SRAM, 1);
		rest();
		check(waited > 2, 1);
		req(1, 1, 32'h5000_0050, TGT_SRAM, 1);
		rest();
		check(waited > 2, 1);
		req(1, 1, 32'h0400_0010, TGT_NONE, 0);
		REQ_VALID <= 0;
		@(negedge CLK);
		check({TCM_SEL, TCM_ADDR}, {1'b1, 32'h0400_0010});
		@(posedge CLK);
		rd(32'h4000_9000, TGT_SRAM, 1);
		SRAM_SIZE_SEL <= SRAM_64K;
		repeat (2) @(posedge CLK);
		rd(32'h4000_9000, TGT_SRAM, 0);
		rd(32'h4001_0000, TGT_SRAM, 1);
		rd(32'h5800_2000, TGT_BRIDGE0, 0);
		rd(32'h5c00_3004, TGT_BRIDGE1, 0);
		SRAM_SIZE_SEL <= SRAM_96K;
		repeat (2) @(posedge CLK);
		rd(32'h4001_0000, TGT_SRAM, 0);
		rd(32'h4001_8000, TGT_SRAM, 1);
		SRAM_SIZE_SEL <= 2'h3;
		repeat (2) @(posedge CLK);
		rd(32'h4000_9000, TGT_SRAM, 1);
		req(1, 0, 32'h0400_0020, TGT_NONE, 0);
		REQ_VALID <= 0;
		@(negedge CLK);
		check({REQ_ERROR, TCM_SEL}, 2'h2);
		@(posedge CLK);
		repeat (4) @(posedge CLK);
		check(notes.size(), 0);
		check(BUFFER_EMPTY, 1);
		conclude();
	end
endmodule : testbench
